// ===== intc_consts.vh
// constants for the cpu interrupt controller
// How it works
// R01: with round robin on, last acknowledged normal vector ranks lowest next time.
// R02: compact vector mode bit shrinks table to three entries, nmi at vector 1.
// R03: in compact mode the high-level interrupt goes to vector 2.
// R04: in compact mode all normal-level sources share vector 3.
// R05: unlock key then protected write within four instructions; only then accepted.
// R06: protected write outside the window is acknowledged but changes nothing except the refused bit in irq status.
// R07: a source event sets its flag bit in the flag register.
// R08: software enables each source through its enable bit.
// R09: request raised only while enable and flag are both set.
// R10: request stays raised until the flag is cleared.
// R11: global enable cleared blocks every maskable request.
// R12: global enable is never cleared by hardware on interrupt entry.
// R13: nmi beats high level, high level beats normal level.
`ifndef INTC_CONSTS_VH
`define INTC_CONSTS_VH
// ************************************************
// register byte addresses (index times four)
// ************************************************
`define ADDR_VECTOR_CONTROL 6'h00
`define ADDR_STATUS 6'h04
`define ADDR_NORMAL_PRIORITY 6'h08
`define ADDR_HIGH_VECTOR 6'h0C
`define ADDR_FLAGS 6'h10
`define ADDR_ENABLES 6'h14
`define ADDR_GUARD 6'h18
`define ADDR_GLOBAL 6'h1C
`define ADDR_IRQ_STATUS 6'h20
`define ADDR_IRQ_MASK 6'h24
// ************************************************
// fields
// ************************************************
`define BIT_ROUND_ROBIN 0
`define BIT_COMPACT 5
`define BIT_VECTOR_SELECT 6
`define BIT_NORMAL_EX 0
`define BIT_HIGH_EX 1
`define BIT_NMI_EX 7
`define BIT_GLOBAL_ENABLE 7
`define UNLOCK_KEY 8'hD8
`define GUARD_WINDOW 3'h4
`define VEC_NMI_COMPACT 8'h01
`define VEC_HIGH_COMPACT 8'h02
`define VEC_NORMAL_COMPACT 8'h03
`define VEC_BASE 8'h03
`define RESET_BYTE 8'h00
`define IRQ_EV_TAKEN 0
`define IRQ_EV_REFUSED 1
`endif

// ===== intc_arbiter.v
// round-robin picker over the normal-level requests
`timescale 1ns/1ps
module intc_arbiter (
  // requests
  input wire [7:0] req,
  input wire [7:0] last_taken,
  input wire rr_enable,
  input wire [7:0] fixed_pri,
  // result
  output reg hit,
  output reg [2:0] pick
);
  reg [2:0] start;
  reg [2:0] idx;
  integer k;
  always @* begin
    hit = 1'b0;
    pick = 3'h0;
    idx = 3'h0;
    // rotate so the slot after the last taken is searched first
    start = rr_enable ? (last_taken[2:0] + 3'h1) : fixed_pri[2:0]; // R01
    for (k = 0; k < 8; k = k + 1) begin
      idx = start + k[2:0];
      if (!hit && req[idx]) begin
        hit = 1'b1;
        pick = idx;
      end
    end
  end
endmodule

// ===== intc_top.v
// interrupt controller with wishbone register slave
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`include "intc_consts.vh"
module intc_top (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire wb_err_o,
  // peripheral event pulses, one per normal-level source
  input wire [7:0] src_event,
  input wire nmi_req,
  // processor side
  input wire cpu_ack,
  input wire cpu_reti,
  input wire instr_retire,
  output reg cpu_req,
  output reg [7:0] cpu_vector,
  // summary interrupt
  output wire irq
);
  // ************************************************
  // registers
  // ************************************************
  reg [7:0] ctrl_reg;
  reg [7:0] pri_reg;
  reg [7:0] hvec_reg;
  reg [7:0] flag_reg;
  reg [7:0] en_reg;
  reg global_reg;
  reg [2:0] guard_reg;
  reg nmi_ex_reg;
  reg high_ex_reg;
  reg normal_ex_reg;
  reg [7:0] last_reg;
  reg [1:0] ist_reg;
  reg [1:0] imask_reg;
  reg [2:0] nmi_sync_reg;
  reg nmi_level_reg;
  reg nmi_pend_reg;
  reg [1:0] state_reg;
  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;
  reg [7:0] taken_vec_reg;
  reg taken_nmi_reg;
  reg taken_high_reg;

  wire wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  wire rd_stb = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  wire unlocked = (guard_reg != 3'h0);
  wire [7:0] wbyte = wb_dat_i[7:0];
  assign wb_err_o = 1'b0;

  // ************************************************
  // request generation
  // ************************************************
  wire [7:0] raw_req = flag_reg & en_reg; // R09 R10
  wire [7:0] norm_req = raw_req & {8{global_reg}}; // R11
  wire [7:0] high_mask = 8'h01 << hvec_reg[2:0];
  wire high_cfg = (hvec_reg != 8'h00);
  wire [7:0] high_req = high_cfg ? (norm_req & high_mask) : 8'h00;
  wire [7:0] low_req = norm_req & ~high_req;
  wire arb_hit;
  wire [2:0] arb_pick;
  intc_arbiter u_arb (
    .req(low_req),
    .last_taken(last_reg),
    .rr_enable(ctrl_reg[`BIT_ROUND_ROBIN]),
    .fixed_pri(pri_reg),
    .hit(arb_hit),
    .pick(arb_pick)
  );

  // ************************************************
  // dispatch: nmi over high over normal
  // ************************************************
  reg want;
  reg [7:0] want_vec;
  reg want_nmi;
  reg want_high;
  always @* begin
    want = 1'b0;
    want_vec = 8'h00;
    want_nmi = 1'b0;
    want_high = 1'b0;
    if (nmi_pend_reg && !nmi_ex_reg) begin // R13
      want = 1'b1;
      want_nmi = 1'b1;
      want_vec = `VEC_NMI_COMPACT; // R02
    end else if (|high_req && !high_ex_reg && !nmi_ex_reg) begin
      want = 1'b1;
      want_high = 1'b1;
      want_vec = ctrl_reg[`BIT_COMPACT] ? `VEC_HIGH_COMPACT : hvec_reg; // R03
    end else if (arb_hit && !normal_ex_reg && !high_ex_reg && !nmi_ex_reg) begin
      want = 1'b1;
      // compact mode folds every normal source onto one slot
      want_vec = ctrl_reg[`BIT_COMPACT] ? `VEC_NORMAL_COMPACT
                                        : ({5'h00, arb_pick} + `VEC_BASE + 8'h01); // R04
    end
  end

  // nmi pin from another domain: three stages, second and third agree
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      nmi_sync_reg <= 3'h0;
      nmi_level_reg <= 1'b0;
    end else begin
      nmi_sync_reg <= {nmi_sync_reg[1:0], nmi_req};
      if (nmi_sync_reg[1] == nmi_sync_reg[2]) begin
        nmi_level_reg <= nmi_sync_reg[2];
      end
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      cpu_req <= 1'b0;
      cpu_vector <= 8'h00;
      taken_vec_reg <= 8'h00;
      taken_nmi_reg <= 1'b0;
      taken_high_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (want) begin
            cpu_req <= 1'b1;
            cpu_vector <= want_vec;
            taken_vec_reg <= {5'h00, arb_pick};
            taken_nmi_reg <= want_nmi;
            taken_high_reg <= want_high;
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (cpu_ack) begin
            cpu_req <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          cpu_req <= 1'b0;
        end
      endcase
    end
  end

  wire take = (state_reg == ST_WAIT) && cpu_ack;
  wire take_normal = take && !taken_nmi_reg && !taken_high_reg;

  // ************************************************
  // register decode
  // ************************************************
  wire wr_ctrl = wr_stb && (wb_adr_i == `ADDR_VECTOR_CONTROL);
  wire wr_pri = wr_stb && (wb_adr_i == `ADDR_NORMAL_PRIORITY);
  wire wr_hvec = wr_stb && (wb_adr_i == `ADDR_HIGH_VECTOR);
  wire wr_flags = wr_stb && (wb_adr_i == `ADDR_FLAGS);
  wire wr_en = wr_stb && (wb_adr_i == `ADDR_ENABLES);
  wire wr_guard = wr_stb && (wb_adr_i == `ADDR_GUARD);
  wire wr_global = wr_stb && (wb_adr_i == `ADDR_GLOBAL);
  wire wr_ist = wr_stb && (wb_adr_i == `ADDR_IRQ_STATUS);
  wire wr_imask = wr_stb && (wb_adr_i == `ADDR_IRQ_MASK);
  // a locked write still gets its ack, it just lands nowhere
  wire refused = (wr_ctrl || wr_hvec) && !unlocked; // R06
  wire [7:0] flag_clr = wr_flags ? wbyte : 8'h00;
  wire [1:0] ist_clr = wr_ist ? wbyte[1:0] : 2'h0;
  wire [1:0] ist_set = {refused, take};

  // ************************************************
  // change guard
  // ************************************************
  // window counts retired instructions after the key, not bus cycles
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      guard_reg <= 3'h0;
    end else if (wr_guard && wbyte == `UNLOCK_KEY) begin
      guard_reg <= `GUARD_WINDOW; // R05
    end else if (instr_retire && unlocked) begin
      guard_reg <= guard_reg - 3'h1;
    end
  end

  // ************************************************
  // configuration
  // ************************************************
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= `RESET_BYTE;
      pri_reg <= `RESET_BYTE;
      hvec_reg <= `RESET_BYTE;
      en_reg <= `RESET_BYTE;
      global_reg <= 1'b0;
      imask_reg <= 2'h0;
    end else begin
      if (wr_ctrl && unlocked) begin
        ctrl_reg <= wbyte & 8'h61; // R05 R06
      end
      if (wr_hvec && unlocked) begin
        hvec_reg <= wbyte; // R06
      end
      if (wr_pri) begin
        pri_reg <= wbyte;
      end
      if (wr_en) begin
        en_reg <= wbyte; // R08
      end
      // only software touches global enable, never dispatch
      if (wr_global) begin
        global_reg <= wbyte[`BIT_GLOBAL_ENABLE]; // R12
      end
      if (wr_imask) begin
        imask_reg <= wbyte[1:0];
      end
    end
  end

  // ************************************************
  // source flags
  // ************************************************
  // write one clears; an event in the same cycle wins over the clear
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_reg <= `RESET_BYTE;
    end else begin
      flag_reg <= (flag_reg & ~flag_clr) | src_event; // R07
    end
  end

  // ************************************************
  // nmi pending and running
  // ************************************************
  // a held pin keeps the nmi pending; only a take with the pin low clears it
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      nmi_pend_reg <= 1'b0;
      nmi_ex_reg <= 1'b0;
    end else begin
      if (nmi_level_reg) begin
        nmi_pend_reg <= 1'b1;
      end else if (take && taken_nmi_reg) begin
        nmi_pend_reg <= 1'b0;
      end
      if (take && taken_nmi_reg) begin
        nmi_ex_reg <= 1'b1;
      end else if (cpu_reti && nmi_ex_reg) begin
        nmi_ex_reg <= 1'b0;
      end
    end
  end

  // ************************************************
  // maskable levels running
  // ************************************************
  // a return closes the deepest level that is running
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      high_ex_reg <= 1'b0;
      normal_ex_reg <= 1'b0;
    end else begin
      if (take && taken_high_reg) begin
        high_ex_reg <= 1'b1;
      end else if (cpu_reti && !nmi_ex_reg && high_ex_reg) begin
        high_ex_reg <= 1'b0;
      end
      if (take_normal) begin
        normal_ex_reg <= 1'b1;
      end else if (cpu_reti && !nmi_ex_reg && !high_ex_reg) begin
        normal_ex_reg <= 1'b0;
      end
    end
  end

  // ************************************************
  // round-robin memory
  // ************************************************
  // only normal-level takes move the rotation point
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_reg <= `RESET_BYTE;
    end else if (take_normal) begin
      last_reg <= taken_vec_reg; // R01
    end
  end

  // ************************************************
  // irq status, set wins over write-one-clear
  // ************************************************
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ist_reg <= 2'h0;
    end else begin
      ist_reg <= ist_set | (ist_reg & ~ist_clr);
    end
  end

  assign irq = |(ist_reg & imask_reg);

  // ************************************************
  // bus answer, one cycle after the request
  // ************************************************
  reg [7:0] rd_byte;
  always @* begin
    case (wb_adr_i)
      `ADDR_VECTOR_CONTROL: rd_byte = ctrl_reg;
      `ADDR_STATUS: rd_byte = {nmi_ex_reg, 5'h00, high_ex_reg, normal_ex_reg};
      `ADDR_NORMAL_PRIORITY: rd_byte = pri_reg;
      `ADDR_HIGH_VECTOR: rd_byte = hvec_reg;
      `ADDR_FLAGS: rd_byte = flag_reg;
      `ADDR_ENABLES: rd_byte = en_reg;
      `ADDR_GUARD: rd_byte = {5'h00, guard_reg};
      `ADDR_GLOBAL: rd_byte = {global_reg, 7'h00};
      `ADDR_IRQ_STATUS: rd_byte = {6'h00, ist_reg};
      `ADDR_IRQ_MASK: rd_byte = {6'h00, imask_reg};
      default: rd_byte = 8'h00;
    endcase
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (rd_stb) begin
        wb_dat_o <= {24'h000000, rd_byte};
      end
    end
  end
endmodule

// ===== cpu_model.sv
// processor core model: takes offers, runs a short handler, retires instructions
`timescale 1ns/1ps
module cpu_model (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  // offer from the controller
  input wire cpu_req,
  input wire [7:0] cpu_vector,
  // bench controls
  input wire [1:0] slow,
  input wire run,
  // core side
  output logic cpu_ack,
  output logic cpu_reti,
  output logic instr_retire,
  output logic [7:0] last_vec,
  output int taken
);
  logic [2:0] busy_reg;
  logic [1:0] wait_reg;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_ack <= 1'b0;
      cpu_reti <= 1'b0;
      instr_retire <= 1'b0;
      last_vec <= 8'h00;
      taken <= 0;
      busy_reg <= 3'h0;
      wait_reg <= 2'h0;
    end else begin
      cpu_ack <= 1'b0;
      // handler runs four cycles, then returns
      cpu_reti <= (busy_reg == 3'h1);
      // retires only while the bench lets software run
      instr_retire <= run;
      if (busy_reg != 3'h0) begin
        busy_reg <= busy_reg - 3'h1;
      end else if (cpu_req && !cpu_ack) begin
        if (wait_reg == slow) begin
          cpu_ack <= 1'b1;
          last_vec <= cpu_vector;
          taken <= taken + 1;
          busy_reg <= 3'h4;
          wait_reg <= 2'h0;
        end else begin
          wait_reg <= wait_reg + 2'h1;
        end
      end
    end
  end
endmodule

// ===== intc_top_checker.sv
// assertions on the controller's bus and processor ports
`timescale 1ns/1ps
module intc_top_checker (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  // bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire wb_err_o,
  input wire [31:0] wb_dat_o,
  // processor
  input wire cpu_ack,
  input wire cpu_req,
  input wire [7:0] cpu_vector
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_offer;
    cpu_req && !cpu_ack;
  endsequence
  chk_ack_next: assert property (s_bus_req |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_err_never: assert property (!wb_err_o)
    else $error("error response seen");
  chk_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  chk_offer_held: assert property (s_offer |=> cpu_req)
    else $error("offer withdrawn before ack");
  chk_offer_drop: assert property (cpu_req && cpu_ack |=> !cpu_req)
    else $error("offer kept after ack");
  chk_vector_valid: assert property ($rose(cpu_req) |-> cpu_vector != 8'h00)
    else $error("offer with vector zero");
endmodule

// ===== intc_top_tb.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`include "intc_consts.vh"
module intc_top_tb;
  logic core_clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, nmi = 1'b0;
  logic run = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [7:0] dat = 8'h00, ev = 8'h00, rd, v1;
  logic [1:0] slow = 2'h0;
  logic [31:0] lf = 32'h697DEFCE;
  wire [31:0] dat_o;
  wire ack, req, cack, reti, ret, irq;
  wire [7:0] vec, lvec;
  int taken, n0, i, n_errors = 0, num_checks = 0, cyc_n = 0;
  intc_top i_intc_top(.core_clk, .arst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i({24'h000000, dat}), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .wb_err_o(), .src_event(ev), .nmi_req(nmi), .cpu_ack(cack),
    .cpu_reti(reti), .instr_retire(ret), .cpu_req(req), .cpu_vector(vec), .irq);
  cpu_model i_cpu_model(.core_clk, .arst_n, .cpu_req(req), .cpu_vector(vec), .slow, .run,
    .cpu_ack(cack), .cpu_reti(reti), .instr_retire(ret), .last_vec(lvec), .taken);
  function automatic [31:0] nx(input [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always #10 core_clk = ~core_clk;
  // whole run needs well under this many cycles
  always @(posedge core_clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task cmp(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge core_clk);
      t++;
    end while (ack !== 1'b1);
    rd = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    // ack is due one cycle after the request is taken
    cmp(8'(t), 8'h02);
  endtask
  task pulse(input logic [7:0] m);
    @(posedge core_clk);
    ev <= m;
    @(posedge core_clk);
    ev <= 8'h00;
  endtask
  // e of zero accepts any vector, kept in v1
  task take(input logic [7:0] e);
    int t0, t;
    t0 = taken;
    t = 0;
    while (taken == t0 && t < 60) begin
      @(posedge core_clk);
      t++;
    end
    v1 = lvec;
    if (taken == t0) cmp(8'hEE, e);
    else if (e != 8'h00) cmp(lvec, e);
  endtask
  task key;
    bus(1'b1, `ADDR_GUARD, `UNLOCK_KEY);
  endtask
  // offers already in flight drain through the core model
  task clean;
    bus(1'b1, `ADDR_GLOBAL, 8'h00);
    bus(1'b1, `ADDR_ENABLES, 8'h00);
    bus(1'b1, `ADDR_FLAGS, 8'hFF);
    repeat (12) @(posedge core_clk);
  endtask
  // ************************************************
  // scenarios
  // ************************************************
  initial begin
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    for (i = 0; i < 4; i++) begin
      bus(1'b0, 6'(i * 4), 8'h00);
      cmp(rd, `RESET_BYTE);
    end
    bus(1'b1, `ADDR_IRQ_MASK, 8'h02);
    bus(1'b1, `ADDR_VECTOR_CONTROL, 8'h21);
    bus(1'b0, `ADDR_VECTOR_CONTROL, 8'h00);
    cmp(rd, 8'h00);
    #1 cmp({7'h00, irq}, 8'h01);
    bus(1'b1, `ADDR_IRQ_STATUS, 8'h02);
    #1 cmp({7'h00, irq}, 8'h00);
    key();
    run <= 1'b1;
    repeat (6) @(posedge core_clk);
    run <= 1'b0;
    bus(1'b1, `ADDR_VECTOR_CONTROL, 8'h01);
    bus(1'b0, `ADDR_VECTOR_CONTROL, 8'h00);
    cmp(rd, 8'h00);
    key();
    // bits outside the three control fields read back as zero
    bus(1'b1, `ADDR_VECTOR_CONTROL, 8'hDF);
    bus(1'b0, `ADDR_VECTOR_CONTROL, 8'h00);
    cmp(rd, 8'h41);
    for (i = 0; i < 8; i++) begin
      lf = nx(lf);
      slow <= lf[1:0];
      bus(1'b1, `ADDR_ENABLES, 8'h01 << i);
      n0 = taken;
      pulse(8'h01 << i);
      repeat (10) @(posedge core_clk);
      cmp(8'(taken - n0), 8'h00);
      bus(1'b1, `ADDR_GLOBAL, 8'h80);
      take(8'(4 + i));
      bus(1'b0, `ADDR_GLOBAL, 8'h00);
      cmp(rd, 8'h80);
      bus(1'b0, `ADDR_FLAGS, 8'h00);
      cmp(rd, 8'h01 << i);
      clean();
    end
    bus(1'b1, `ADDR_ENABLES, 8'h03);
    bus(1'b1, `ADDR_GLOBAL, 8'h80);
    pulse(8'h03);
    take(8'h00);
    cmp(v1 & 8'hFE, 8'h04);
    take(v1 ^ 8'h01);
    take(v1 ^ 8'h01);
    clean();
    // takes and the refused write are both latched
    bus(1'b0, `ADDR_IRQ_STATUS, 8'h00);
    cmp(rd, 8'h03);
    bus(1'b1, `ADDR_IRQ_STATUS, 8'h01);
    bus(1'b0, `ADDR_IRQ_STATUS, 8'h00);
    cmp(rd, 8'h02);
    bus(1'b1, `ADDR_ENABLES, 8'h01);
    pulse(8'h01);
    // a short pin pulse: a held pin would keep the nmi pending
    nmi <= 1'b1;
    repeat (2) @(posedge core_clk);
    nmi <= 1'b0;
    take(8'h01);
    bus(1'b1, `ADDR_GLOBAL, 8'h80);
    take(8'h04);
    clean();
    // rotation off: the search starts at the stored priority every time
    key();
    bus(1'b1, `ADDR_VECTOR_CONTROL, 8'h00);
    bus(1'b1, `ADDR_NORMAL_PRIORITY, 8'h03);
    bus(1'b1, `ADDR_ENABLES, 8'h09);
    bus(1'b1, `ADDR_GLOBAL, 8'h80);
    pulse(8'h09);
    take(8'h07);
    take(8'h07);
    clean();
    key();
    bus(1'b1, `ADDR_VECTOR_CONTROL, 8'h20);
    key();
    bus(1'b1, `ADDR_HIGH_VECTOR, 8'h02);
    bus(1'b1, `ADDR_ENABLES, 8'h05);
    bus(1'b1, `ADDR_GLOBAL, 8'h80);
    pulse(8'h01);
    take(`VEC_NORMAL_COMPACT);
    clean();
    bus(1'b1, `ADDR_ENABLES, 8'h04);
    bus(1'b1, `ADDR_GLOBAL, 8'h80);
    pulse(8'h04);
    take(`VEC_HIGH_COMPACT);
    clean();
    nmi <= 1'b1;
    repeat (2) @(posedge core_clk);
    nmi <= 1'b0;
    take(`VEC_NMI_COMPACT);
    bus(1'b0, 6'h3C, 8'h00);
    report_and_stop();
  end
endmodule
bind intc_top intc_top_checker i_intc_top_checker(.core_clk, .arst_n, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .wb_err_o, .wb_dat_o, .cpu_ack, .cpu_req, .cpu_vector);
